/* File: verilog/fuel_gauge_ctrl.sv */
// control register, pin control register, sleep entry, blanking and display
// assumes a byte register port from the serial bus front end and nv memory
// that presents the stored control byte whenever reset is released
`timescale 1ns/1ns
`include "fuel_gauge_params.svh"
// Contract
// - control byte loaded from nonvolatile memory at power up, software may change it
// - copy command stores current control byte as next power up default
// - blanking bit drops small negative current readings from accumulation
// - undervoltage sleep bit allows sleep on low voltage and steady bus
// - bus sleep bit allows sleep when bus stays low for sleep delay
// - opcode select bit picks read net address opcode 33h or 39h
// - led count bit picks five led or four led map
// - pin control bit reads back sensed pin level
// - writing zero drives pin low, writing one releases it
// - pin control bit becomes one at power up and on sleep entry
// - five open drain outputs show relative capacity on four or five leds
// - display starts on rising pin edge while pin is released
// - display stays lit four seconds then turns off regardless of pin
// - pin debounced for 100 ms, later edges restart display
// - blinking led alternates half second driven, half second released
// - lit led output driven low, unlit output released
// - five led map thresholds 10, 20, 40, 60, 80
// - four led map thresholds 10, 25, 50, 75
// - displayed value is the eight bit relative capacity percentage
module fuel_gauge_ctrl
    import fuel_gauge_pkg::*;
#(
    parameter int unsigned DISP_CYC = `DISP_TIME_MS * `CLK_FREQ_KHZ,
    parameter int unsigned DEB_CYC = `DEBOUNCE_MS * `CLK_FREQ_KHZ,
    parameter int unsigned HALF_CYC = `BLINK_HALF_MS * `CLK_FREQ_KHZ,
    parameter int unsigned SLEEP_CYC = `SLEEP_TIME_MS * `CLK_FREQ_KHZ,
    parameter int unsigned CUR_LSB_NV = 1000
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // register port from the serial bus front end
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic copy_nv,
    // nonvolatile control byte
    input wire logic [7:0] nv_ctrl_default,
    output logic nv_store,
    output logic [7:0] nv_store_data,
    // current readings
    input wire logic signed [15:0] cur_sample,
    input wire logic cur_valid,
    output logic accum_valid,
    output logic signed [15:0] accum_sample,
    // capacity result
    input wire logic [7:0] active_rel_capacity_pct,
    // sleep sensing
    input wire logic bus_line,
    input wire logic sensed_input_voltage_low,
    output logic sleep_enter,
    output logic [7:0] net_addr_opcode,
    // general purpose pin, open drain
    input wire logic gp_button_pin_in,
    output logic gp_button_pin_out,
    output logic gp_button_pin_oe,
    // led bar, open drain
    output logic [4:0] bar_out_out,
    output logic [4:0] bar_out_oe
);
    localparam logic signed [15:0] BLANK_NEG =
        -16'(`NEG_BLANK_UV * 1000 / CUR_LSB_NV);

    disp_if dp ();

    byte_t ctrl;
    logic loaded;
    logic gp_pin_sense_ctrl;
    logic [1:0] pin_sync;
    logic [1:0] bus_sync;
    logic [1:0] uv_sync;
    logic bus_prev;
    logic [31:0] sleep_cnt;
    sleep_state_e sleep_st;
    sleep_state_e next_sleep_st;
    logic sleep_cond;
    logic neg_blank_enable;
    logic undervolt_sleep_enable;
    logic bus_low_sleep_enable;
    logic net_addr_opcode_select;
    logic led_count_select;

    // ----------------------------------------
    // control byte fields
    // ----------------------------------------
    assign neg_blank_enable = ctrl[`BIT_NEG_BLANK];
    assign undervolt_sleep_enable = ctrl[`BIT_UV_SLEEP];
    assign bus_low_sleep_enable = ctrl[`BIT_BUS_SLEEP];
    assign net_addr_opcode_select = ctrl[`BIT_NET_OPSEL];
    assign led_count_select = ctrl[`BIT_LED_COUNT];

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // two stages for each outside level
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pin_sync <= 2'h0;
            bus_sync <= 2'h0;
            uv_sync <= 2'h0;
        end else begin
            pin_sync <= {pin_sync[0], gp_button_pin_in};
            bus_sync <= {bus_sync[0], bus_line};
            uv_sync <= {uv_sync[0], sensed_input_voltage_low};
        end
    end

    // ----------------------------------------
    // control register
    // ----------------------------------------
    // nv byte taken on the first edge after reset, then software writes
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl <= 8'h00;
            loaded <= 1'b0;
        end else if (!loaded) begin
            ctrl <= nv_ctrl_default & `CTRL_USED_MASK;
            loaded <= 1'b1;
        end else if (reg_wr && reg_addr == `ADDR_DEV_CTRL) begin
            ctrl <= reg_wdata & `CTRL_USED_MASK;
        end
    end

    // copy command hands the shadow byte to nv memory
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            nv_store <= 1'b0;
            nv_store_data <= 8'h00;
        end else begin
            nv_store <= copy_nv && loaded;
            if (copy_nv && loaded) begin
                nv_store_data <= ctrl;
            end
        end
    end

    // read net address opcode follows the select bit
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            net_addr_opcode <= `OPCODE_NET_ADDR_A;
        end else begin
            net_addr_opcode <= net_addr_opcode_select ? `OPCODE_NET_ADDR_B
                                                      : `OPCODE_NET_ADDR_A;
        end
    end

    // ----------------------------------------
    // pin control register
    // ----------------------------------------
    // sleep entry releases the pin, and wins over a same cycle write
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            gp_pin_sense_ctrl <= `PIN_CTRL_RESET;
        end else if (sleep_enter) begin
            gp_pin_sense_ctrl <= `PIN_CTRL_RESET;
        end else if (reg_wr && reg_addr == `ADDR_PIN_CTRL) begin
            gp_pin_sense_ctrl <= reg_wdata[`BIT_PIN_SENSE];
        end
    end

    // open drain pin driver
    assign gp_button_pin_out = 1'b0;
    assign gp_button_pin_oe = !gp_pin_sense_ctrl;

    // ----------------------------------------
    // register reads
    // ----------------------------------------
    // one cycle after the strobe, unmapped offsets read zero
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `ADDR_DEV_CTRL: reg_rdata <= ctrl;
                `ADDR_PIN_CTRL: reg_rdata <= {7'h00, pin_sync[1]};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // negative current blanking
    // ----------------------------------------
    // small negative readings are dropped when blanking is on
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            accum_valid <= 1'b0;
            accum_sample <= 16'sh0000;
        end else begin
            accum_valid <= cur_valid && !(neg_blank_enable && cur_sample < 16'sh0000
                && cur_sample >= BLANK_NEG);
            accum_sample <= cur_sample;
        end
    end

    // ----------------------------------------
    // sleep entry
    // ----------------------------------------
    // conditions that may lead to sleep
    assign sleep_cond = (bus_low_sleep_enable && !bus_sync[1])
        || (undervolt_sleep_enable && uv_sync[1]);

    // next state of the sleep sequencer
    always_comb begin
        next_sleep_st = sleep_st;
        case (sleep_st)
            sl_awake: begin
                if (sleep_cond) begin
                    next_sleep_st = sl_count;
                end
            end
            sl_count: begin
                if (!sleep_cond || bus_sync[1] != bus_prev) begin
                    next_sleep_st = sl_awake;
                end else if (sleep_cnt == SLEEP_CYC - 1) begin
                    next_sleep_st = sl_asleep;
                end
            end
            sl_asleep: begin
                if (!sleep_cond || bus_sync[1] != bus_prev) begin
                    next_sleep_st = sl_awake;
                end
            end
            default: next_sleep_st = sl_awake;
        endcase
    end

    // state, steady time counter and entry pulse
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sleep_st <= sl_awake;
            sleep_cnt <= 32'h0000_0000;
            bus_prev <= 1'b0;
            sleep_enter <= 1'b0;
        end else begin
            sleep_st <= next_sleep_st;
            bus_prev <= bus_sync[1];
            sleep_enter <= sleep_st == sl_count && next_sleep_st == sl_asleep;
            if (next_sleep_st == sl_count && sleep_st == sl_count) begin
                sleep_cnt <= sleep_cnt + 32'h0000_0001;
            end else begin
                sleep_cnt <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------
    // led display
    // ----------------------------------------
    assign dp.gp_level = pin_sync[1];
    assign dp.gp_released = gp_pin_sense_ctrl;
    assign dp.capacity = active_rel_capacity_pct;
    assign dp.four_led = led_count_select;

    led_bar_display #(
        .DISP_CYC(DISP_CYC),
        .DEB_CYC(DEB_CYC),
        .HALF_CYC(HALF_CYC)
    ) u_display (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .dp(dp)
    );

    // lit leds pull low, unlit stay released
    assign bar_out_out = 5'h00;
    assign bar_out_oe = dp.led_lit;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_cfg_write;
        loaded && reg_wr && reg_addr == `ADDR_DEV_CTRL;
    endsequence
    sequence s_read_back;
        ##1 (reg_rdata == {7'h00, $past(pin_sync[1])});
    endsequence

    nv_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !loaded |=> ctrl == (($past(nv_ctrl_default)) & `CTRL_USED_MASK))
        else $error("control byte not loaded from nv");
    ctrl_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_cfg_write |=> ctrl == ($past(reg_wdata) & `CTRL_USED_MASK))
        else $error("control write lost");
    nv_copy_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        copy_nv && loaded |=> nv_store && nv_store_data == $past(ctrl))
        else $error("copy did not store control byte");
    blank_drop_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cur_valid && neg_blank_enable && cur_sample == -16'sh0001 |=> !accum_valid)
        else $error("small negative reading not blanked");
    blank_pass_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cur_valid && !neg_blank_enable |=> accum_valid)
        else $error("reading dropped with blanking off");
    opcode_sel_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ##1 net_addr_opcode == ($past(net_addr_opcode_select) ? `OPCODE_NET_ADDR_B
                                                              : `OPCODE_NET_ADDR_A))
        else $error("wrong net address opcode");
    pin_sense_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_rd && reg_addr == `ADDR_PIN_CTRL |-> s_read_back)
        else $error("pin level not read back");
    pin_drive_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_wr && reg_addr == `ADDR_PIN_CTRL && !reg_wdata[0] && !sleep_enter
        |=> gp_button_pin_oe)
        else $error("pin not driven after zero write");
    sleep_release_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        sleep_enter |=> !gp_button_pin_oe)
        else $error("pin not released on sleep");
    sleep_steady_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        sleep_enter |-> $past(sleep_cond) && $past(sleep_st) == sl_count)
        else $error("sleep entered without condition");
endmodule

/* File: verilog/fuel_gauge_params.svh */
// constants for the fuel gauge control and display logic
// assumes a 10 MHz ref_clk and byte-wide register accesses
`ifndef FUEL_GAUGE_PARAMS_SVH
`define FUEL_GAUGE_PARAMS_SVH
// ----------------------------------------
// register offsets and fields
// ----------------------------------------
`define ADDR_PIN_CTRL 8'h15
`define ADDR_DEV_CTRL 8'h60
`define BIT_NEG_BLANK 7
`define BIT_UV_SLEEP 6
`define BIT_BUS_SLEEP 5
`define BIT_NET_OPSEL 4
`define BIT_LED_COUNT 3
`define BIT_PIN_SENSE 0
`define CTRL_USED_MASK 8'hf8
`define PIN_CTRL_RESET 1'b1
`define OPCODE_NET_ADDR_A 8'h33
`define OPCODE_NET_ADDR_B 8'h39
// ----------------------------------------
// timing, in milliseconds, clock rate, and blanking level in microvolts
// ----------------------------------------
`define CLK_FREQ_KHZ 10000
`define DISP_TIME_MS 4000
`define DEBOUNCE_MS 100
`define BLINK_HALF_MS 500
`define SLEEP_TIME_MS 2000
`define NEG_BLANK_UV 25
// ----------------------------------------
// display thresholds, percent
// ----------------------------------------
`define CAP_BLINK 8'h0a
`define CAP5_T2 8'h14
`define CAP5_T3 8'h28
`define CAP5_T4 8'h3c
`define CAP5_T5 8'h50
`define CAP4_T2 8'h19
`define CAP4_T3 8'h32
`define CAP4_T4 8'h4b
`define CAP_NEVER 8'hff
`endif

/* File: verilog/fuel_gauge_pkg.sv */
// shared types of the fuel gauge control and display logic
// assumes the constants header is compiled alongside
package fuel_gauge_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {sl_awake, sl_count, sl_asleep} sleep_state_e;
endpackage

/* File: verilog/disp_if.sv */
// signals between the control logic and the led display engine
// assumes both ends run on ref_clk
`timescale 1ns/1ns
interface disp_if;
    logic gp_level;
    logic gp_released;
    logic [7:0] capacity;
    logic four_led;
    logic [4:0] led_lit;
    modport ctrl_side (output gp_level, output gp_released, output capacity,
                       output four_led, input led_lit);
    modport disp_side (input gp_level, input gp_released, input capacity,
                       input four_led, output led_lit);
endinterface

/* File: verilog/led_bar_display.sv */
// led bar display engine: button debounce, display timer, blink, map
// assumes gp_level is already synchronised to ref_clk
`timescale 1ns/1ns
`include "fuel_gauge_params.svh"
module led_bar_display
    import fuel_gauge_pkg::*;
#(
    parameter int unsigned DISP_CYC = `DISP_TIME_MS * `CLK_FREQ_KHZ,
    parameter int unsigned DEB_CYC = `DEBOUNCE_MS * `CLK_FREQ_KHZ,
    parameter int unsigned HALF_CYC = `BLINK_HALF_MS * `CLK_FREQ_KHZ
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // link to control logic
    disp_if.disp_side dp
);
    logic prev_level;
    logic [31:0] deb_cnt;
    logic [31:0] disp_cnt;
    logic [31:0] blink_cnt;
    logic blink_on;
    logic start;
    logic [4:0] next_lit;
    logic [7:0] thr [5];

    // accepted rising edge starts the display
    assign start = dp.gp_released && dp.gp_level && !prev_level && deb_cnt == 32'h0000_0000;

    // edge tracking and debounce window
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            prev_level <= 1'b0;
            deb_cnt <= 32'h0000_0000;
        end else begin
            prev_level <= dp.gp_level;
            if (deb_cnt != 32'h0000_0000) begin
                deb_cnt <= deb_cnt - 32'h0000_0001;
            end else if (dp.gp_level != prev_level) begin
                deb_cnt <= DEB_CYC;
            end
        end
    end

    // display period, fixed length, a held button does not extend it
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            disp_cnt <= 32'h0000_0000;
        end else if (start) begin
            disp_cnt <= DISP_CYC;
        end else if (disp_cnt != 32'h0000_0000) begin
            disp_cnt <= disp_cnt - 32'h0000_0001;
        end
    end

    // blink phase, starts driven at each period start
    always_ff @(posedge ref_clk) begin
        if (sys_rst || start) begin
            blink_cnt <= 32'h0000_0000;
            blink_on <= 1'b1;
        end else if (blink_cnt == HALF_CYC - 1) begin
            blink_cnt <= 32'h0000_0000;
            blink_on <= !blink_on;
        end else begin
            blink_cnt <= blink_cnt + 32'h0000_0001;
        end
    end

    // thresholds per led for the chosen map
    always_comb begin
        thr[0] = `CAP_BLINK;
        thr[1] = dp.four_led ? `CAP4_T2 : `CAP5_T2;
        thr[2] = dp.four_led ? `CAP4_T3 : `CAP5_T3;
        thr[3] = dp.four_led ? `CAP4_T4 : `CAP5_T4;
        thr[4] = dp.four_led ? `CAP_NEVER : `CAP5_T5;
    end

    // per led lit decision
    for (genvar i = 0; i < 5; i++) begin : g_led
        if (i == 0) begin : g_low
            assign next_lit[i] = (disp_cnt != 32'h0000_0000)
                && (dp.capacity > thr[i] || blink_on);
        end else begin : g_up
            assign next_lit[i] = (disp_cnt != 32'h0000_0000) && dp.capacity > thr[i];
        end
    end

    // registered led drive
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dp.led_lit <= 5'h00;
        end else begin
            dp.led_lit <= next_lit;
        end
    end

    sequence s_start;
        start;
    endsequence
    property p_first_on;
        @(posedge ref_clk) disable iff (sys_rst) s_start |=> ##1 dp.led_lit[0];
    endproperty
    blink_starts_driven_a: assert property (p_first_on)
        else $error("lowest led not driven at display start");
    dark_when_idle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        disp_cnt == 32'h0000_0000 |=> dp.led_lit == 5'h00)
        else $error("led lit outside display period");
    four_map_top_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        dp.four_led |=> !dp.led_lit[4])
        else $error("fifth led lit in four led map");
endmodule

/* File: dv/led_button_model.sv */
// far side of the display pins: push button with weak pulldown and led bar
// assumes open-drain enables from the control logic, high = pulling low
`timescale 1ns/1ns
module led_button_model (
    // stimulus from the bench
    input wire logic press,
    // pins from the control logic
    input wire logic gp_button_pin_oe,
    input wire logic [4:0] bar_out_oe,
    // pin levels seen by the bench and the control logic
    output logic gp_button_pin_in,
    output logic [4:0] led_on
);
    // ----------------------------------------
    // pin levels
    // ----------------------------------------
    // driver wins, a pressed button pulls high, else the weak pulldown
    assign gp_button_pin_in = gp_button_pin_oe ? 1'b0 : press;
    // an led glows only while its pin sinks current
    assign led_on = bar_out_oe;
endmodule

/* File: dv/fuel_gauge_ctrl_bench.sv */
// self-checking bench for the fuel gauge control and display logic
// assumes shortened display, debounce, blink and sleep counts
`timescale 1ns/1ns
`include "fuel_gauge_params.svh"
module fuel_gauge_ctrl_bench
    import fuel_gauge_pkg::*;
;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam int LIMIT = 10000;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic copy_nv = 1'b0;
    logic [7:0] active_rel_capacity_pct = 8'h00;
    logic signed [15:0] cur_sample = 16'sh0000;
    logic cur_valid = 1'b0;
    logic bus_line = 1'b1;
    logic vin_low = 1'b0;
    logic press = 1'b0;
    logic [7:0] nv_default = 8'h9f;
    logic [7:0] reg_rdata, nv_store_data, net_addr_opcode;
    logic nv_store, accum_valid, sleep_enter;
    logic signed [15:0] accum_sample;
    logic gp_button_pin_in, gp_button_pin_out, gp_button_pin_oe;
    logic [4:0] bar_out_out, bar_out_oe, led_on;
    int fail_count = 0;
    int num_checks = 0;
    int cyc_count = 0;
    byte_t d;
    localparam byte_t CAP5 [11] = '{8'h0a, 8'h0b, 8'h14, 8'h15, 8'h28, 8'h29, 8'h3c,
                                    8'h3d, 8'h50, 8'h51, 8'h64};
    localparam byte_t EXP5 [11] = '{8'h01, 8'h01, 8'h01, 8'h03, 8'h03, 8'h07, 8'h07,
                                    8'h0f, 8'h0f, 8'h1f, 8'h1f};
    localparam byte_t CAP4 [9] = '{8'h0a, 8'h0b, 8'h19, 8'h1a, 8'h32, 8'h33, 8'h4b,
                                   8'h4c, 8'h64};
    localparam byte_t EXP4 [9] = '{8'h01, 8'h01, 8'h01, 8'h03, 8'h03, 8'h07, 8'h07,
                                   8'h0f, 8'h0f};

    // ----------------------------------------
    // design, pins and clock
    // ----------------------------------------
    fuel_gauge_ctrl #(.DISP_CYC(200), .DEB_CYC(20), .HALF_CYC(25), .SLEEP_CYC(30),
        .CUR_LSB_NV(1000)) fuel_gauge_ctrl_inst (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .copy_nv(copy_nv),
        .nv_ctrl_default(nv_default), .nv_store(nv_store), .nv_store_data(nv_store_data),
        .cur_sample(cur_sample), .cur_valid(cur_valid), .accum_valid(accum_valid),
        .accum_sample(accum_sample), .active_rel_capacity_pct(active_rel_capacity_pct),
        .bus_line(bus_line), .sensed_input_voltage_low(vin_low),
        .sleep_enter(sleep_enter), .net_addr_opcode(net_addr_opcode),
        .gp_button_pin_in(gp_button_pin_in), .gp_button_pin_out(gp_button_pin_out),
        .gp_button_pin_oe(gp_button_pin_oe), .bar_out_out(bar_out_out),
        .bar_out_oe(bar_out_oe));
    led_button_model led_button_model_inst (.press(press),
        .gp_button_pin_oe(gp_button_pin_oe), .bar_out_oe(bar_out_oe),
        .gp_button_pin_in(gp_button_pin_in), .led_on(led_on));
    // free-running clock
    always #50 ref_clk = ~ref_clk;
    // hang guard
    always @(posedge ref_clk) begin
        cyc_count++;
        if (cyc_count == LIMIT) begin
            fail_count++;
            report_and_stop();
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input byte_t got, input byte_t exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic wr(input byte_t a, input byte_t v);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input byte_t a, output byte_t v);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        v = reg_rdata;
    endtask
    task automatic cur(input logic signed [15:0] s, input logic exp);
        @(negedge ref_clk);
        cur_sample = s;
        cur_valid = 1'b1;
        @(negedge ref_clk);
        cur_valid = 1'b0;
        check({7'h00, accum_valid}, {7'h00, exp});
        if (exp) check(accum_sample[7:0], s[7:0]);
    endtask
    task automatic show(input byte_t c, input byte_t e);
        @(negedge ref_clk);
        active_rel_capacity_pct = c;
        press = 1'b1;
        cycles(8);
        check({3'h0, led_on}, e);
        press = 1'b0;
        cycles(30);
    endtask
    task automatic sleep_wait(input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (60) begin
            @(negedge ref_clk);
            if (sleep_enter === 1'b1) seen = 1'b1;
        end
        check({7'h00, seen}, {7'h00, exp});
    endtask
    task automatic report_and_stop();
        $display("checks=%0d failures=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        rd(`ADDR_DEV_CTRL, d);
        check(d, 8'h98);
        check(net_addr_opcode, 8'h39);
        wr(`ADDR_DEV_CTRL, 8'h00);
        rd(`ADDR_DEV_CTRL, d);
        check(d, 8'h00);
        check(net_addr_opcode, 8'h33);
        wr(8'h20, 8'hff);
        rd(8'h20, d);
        check(d, 8'h00);
        rd(`ADDR_DEV_CTRL, d);
        check(d, 8'h00);
        wr(`ADDR_DEV_CTRL, 8'ha8);
        @(negedge ref_clk);
        copy_nv = 1'b1;
        @(negedge ref_clk);
        copy_nv = 1'b0;
        check({7'h00, nv_store}, 8'h01);
        check(nv_store_data, 8'ha8);
    endtask
    task automatic t_blank();
        wr(`ADDR_DEV_CTRL, 8'h80);
        cur(-16'sd25, 1'b0);
        cur(-16'sd1, 1'b0);
        cur(-16'sd26, 1'b1);
        cur(16'sd5, 1'b1);
        wr(`ADDR_DEV_CTRL, 8'h00);
        cur(-16'sd1, 1'b1);
        cur(-16'sd25, 1'b1);
    endtask
    task automatic t_map();
        for (int i = 0; i < 11; i++) show(CAP5[i], EXP5[i]);
        wr(`ADDR_DEV_CTRL, 8'h08);
        for (int i = 0; i < 9; i++) show(CAP4[i], EXP4[i]);
    endtask
    task automatic t_timing();
        wr(`ADDR_DEV_CTRL, 8'h00);
        active_rel_capacity_pct = 8'h05;
        cycles(30);
        press = 1'b1;
        cycles(8);
        check({3'h0, led_on}, 8'h01);
        cycles(32);
        check({3'h0, led_on}, 8'h00);
        cycles(20);
        check({3'h0, led_on}, 8'h01);
        cycles(155);
        check({3'h0, led_on}, 8'h00);
        press = 1'b0;
        cycles(30);
    endtask
    task automatic t_pin();
        wr(`ADDR_PIN_CTRL, 8'h00);
        check({7'h00, gp_button_pin_oe}, 8'h01);
        check({7'h00, gp_button_pin_out}, 8'h00);
        check({3'h0, bar_out_out}, 8'h00);
        press = 1'b1;
        cycles(10);
        rd(`ADDR_PIN_CTRL, d);
        check(d, 8'h00);
        check({3'h0, led_on}, 8'h00);
        wr(`ADDR_PIN_CTRL, 8'h01);
        check({7'h00, gp_button_pin_oe}, 8'h00);
        cycles(5);
        rd(`ADDR_PIN_CTRL, d);
        check(d, 8'h01);
        press = 1'b0;
        cycles(30);
    endtask
    task automatic t_sleep();
        wr(`ADDR_DEV_CTRL, 8'h20);
        wr(`ADDR_PIN_CTRL, 8'h00);
        bus_line = 1'b0;
        sleep_wait(1'b1);
        check({7'h00, gp_button_pin_oe}, 8'h00);
        bus_line = 1'b1;
        wr(`ADDR_DEV_CTRL, 8'h00);
        bus_line = 1'b0;
        sleep_wait(1'b0);
        bus_line = 1'b1;
        wr(`ADDR_DEV_CTRL, 8'h40);
        vin_low = 1'b1;
        sleep_wait(1'b1);
        vin_low = 1'b0;
        wr(`ADDR_DEV_CTRL, 8'h00);
        vin_low = 1'b1;
        sleep_wait(1'b0);
        vin_low = 1'b0;
    endtask
    // edges inside the debounce window are ignored, later ones restart
    task automatic t_debounce();
        active_rel_capacity_pct = 8'h64;
        press = 1'b1;
        cycles(10);
        press = 1'b0;
        cycles(5);
        press = 1'b1;
        cycles(195);
        check({3'h0, led_on}, 8'h00);
        press = 1'b0;
        cycles(30);
        press = 1'b1;
        cycles(8);
        check({3'h0, led_on}, 8'h1f);
        press = 1'b0;
        cycles(30);
    endtask
    // mid-run reset reloads a new nv byte and releases the pin
    task automatic t_reset();
        wr(`ADDR_PIN_CTRL, 8'h00);
        nv_default = 8'h37;
        sys_rst = 1'b1;
        cycles(3);
        sys_rst = 1'b0;
        check({7'h00, gp_button_pin_oe}, 8'h00);
        rd(`ADDR_DEV_CTRL, d);
        check(d, 8'h30);
        check(net_addr_opcode, 8'h39);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        cycles(20);
        sys_rst = 1'b0;
        t_regs();
        t_blank();
        t_map();
        t_timing();
        t_pin();
        t_sleep();
        t_debounce();
        t_reset();
        report_and_stop();
    end
endmodule
